// ==== rtl/nsx_pkg.sv ====
// constants and types shared by the nibble-swap / direction-load / literal-xor executer
package nsx_pkg;
    // ----------------------------------------------------------------
    // instruction word layout
    // ----------------------------------------------------------------
    localparam int INSTR_W   = 14;
    localparam int DATA_W    = 8;
    localparam int FADDR_W   = 7;
    localparam int DIRSEL_W  = 3;
    localparam int OPC_HI    = 13;
    localparam int OPC_LO    = 8;
    localparam int DEST_BIT  = 7;
    localparam int DIRPFX_LO = 3;

    localparam logic [5:0]  OPC_NIBBLE_SWAP = 6'h0E;
    localparam logic [5:0]  OPC_LITERAL_XOR = 6'h3A;
    localparam logic [10:0] OPC_DIR_LOAD    = 11'h00C;

    localparam logic [DIRSEL_W-1:0] DIR_SEL_MIN = 3'h5;
    localparam logic [DIRSEL_W-1:0] DIR_SEL_MAX = 3'h7;
    localparam int                  DIR_COUNT   = 3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] W_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;
    localparam logic              FLAG_RST  = 1'b0;

    typedef enum logic [1:0] {
        NSX_Q1 = 2'b00,
        NSX_Q2 = 2'b01,
        NSX_Q3 = 2'b10,
        NSX_Q4 = 2'b11
    } nsx_phase_type;

    typedef enum logic [1:0] {
        NSX_OP_NONE = 2'b00,
        NSX_OP_SWAP = 2'b01,
        NSX_OP_DIR  = 2'b10,
        NSX_OP_XOR  = 2'b11
    } nsx_op_type;

    function automatic logic nsx_dir_sel_ok(input logic [DIRSEL_W-1:0] sel);
        nsx_dir_sel_ok = (sel >= DIR_SEL_MIN) && (sel <= DIR_SEL_MAX);
    endfunction

    function automatic logic [1:0] nsx_dir_index(input logic [DIRSEL_W-1:0] sel);
        logic [DIRSEL_W-1:0] diff;
        diff = sel - DIR_SEL_MIN;
        nsx_dir_index = diff[1:0];
    endfunction
endpackage

// ==== rtl/nsx_alu.sv ====
// decode and data path of the three instructions
`timescale 1ns/1ns
`default_nettype none
module nsx_alu
    import nsx_pkg::*;
(
    input  wire logic [INSTR_W-1:0] instr,
    input  wire logic [DATA_W-1:0]  opnd,
    input  wire logic [DATA_W-1:0]  w_val,
    output nsx_op_type              op,
    output logic [DATA_W-1:0]       result,
    output logic                    result_zero,
    output logic                    dest_file
);
    // ----------------------------------------------------------------
    // opcode decode
    // ----------------------------------------------------------------
    always_comb begin
        if (instr[OPC_HI:OPC_LO] == OPC_NIBBLE_SWAP) begin
            op = NSX_OP_SWAP;
        end else if (instr[OPC_HI:OPC_LO] == OPC_LITERAL_XOR) begin
            op = NSX_OP_XOR;
        end else if (instr[OPC_HI:DIRPFX_LO] == OPC_DIR_LOAD) begin
            op = NSX_OP_DIR;
        end else begin
            op = NSX_OP_NONE;
        end
    end

    // ----------------------------------------------------------------
    // result
    // ----------------------------------------------------------------
    always_comb begin
        result    = w_val;
        dest_file = 1'b0;
        case (op)
            NSX_OP_SWAP: begin
                result    = {opnd[3:0], opnd[7:4]};
                dest_file = instr[DEST_BIT];
            end
            NSX_OP_XOR: begin
                result = w_val ^ opnd;
            end
            default: begin
                result = w_val;
            end
        endcase
        result_zero = (result == '0);
    end
endmodule
`default_nettype wire

// ==== rtl/nsx_exec.sv ====
// four-quarter executer for nibble swap, direction load and literal xor
`timescale 1ns/1ns
`default_nettype none
module nsx_exec
    import nsx_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [INSTR_W-1:0]  instr_word,
    input  wire logic                file_wr_en,
    input  wire logic [FADDR_W-1:0]  file_wr_addr,
    input  wire logic [DATA_W-1:0]   file_wr_data,
    input  wire logic [FADDR_W-1:0]  file_rd_addr,
    input  wire logic                dir_wr_en,
    input  wire logic [DIRSEL_W-1:0] dir_wr_sel,
    input  wire logic [DATA_W-1:0]   dir_wr_data,
    input  wire logic                status_wr_en,
    input  wire logic [2:0]          status_wr_data,
    output logic [DATA_W-1:0]        file_rd_data,
    output logic [DATA_W-1:0]        w_out,
    output logic                     zero_flag,
    output logic                     carry_flag,
    output logic                     digit_carry_flag,
    output logic [DATA_W-1:0]        dir5_out,
    output logic [DATA_W-1:0]        dir6_out,
    output logic [DATA_W-1:0]        dir7_out,
    output logic [1:0]               phase_out,
    output logic                     retire_pulse,
    output logic                     unknown_op_pulse
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]  file_mem [0:(1<<FADDR_W)-1];
    logic [DATA_W-1:0]  dir_reg  [0:DIR_COUNT-1];
    nsx_phase_type      phase_reg;
    logic [INSTR_W-1:0] instr_reg;
    logic [DATA_W-1:0]  opnd_reg;
    logic [DATA_W-1:0]  res_reg;
    logic               res_zero_reg;
    logic               res_file_reg;
    nsx_op_type         op_reg;
    logic [DATA_W-1:0]  w_reg;
    logic               z_reg;
    logic               c_reg;
    logic               dc_reg;
    logic [DATA_W-1:0]  rd_reg;
    logic               retire_reg;
    logic               unknown_reg;

    nsx_op_type         alu_op;
    logic [DATA_W-1:0]  alu_res;
    logic               alu_zero;
    logic               alu_file;
    logic               commit;
    logic               file_commit;
    logic               dir_commit;
    logic [1:0]         dir_idx;

    nsx_alu u_alu (
        .instr       (instr_reg),
        .opnd        (opnd_reg),
        .w_val       (w_reg),
        .op          (alu_op),
        .result      (alu_res),
        .result_zero (alu_zero),
        .dest_file   (alu_file)
    );

    // ----------------------------------------------------------------
    // quarter sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= NSX_Q1;
        end else begin
            case (phase_reg)
                NSX_Q1: begin
                    phase_reg <= NSX_Q2;
                end
                NSX_Q2: begin
                    phase_reg <= NSX_Q3;
                end
                NSX_Q3: begin
                    phase_reg <= NSX_Q4;
                end
                default: begin
                    phase_reg <= NSX_Q1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // operand fetch
    // ----------------------------------------------------------------
    // q1 decode: latch the word; q2 read: file register or literal byte
    always_ff @(posedge clk) begin
        if (rst) begin
            instr_reg <= '0;
            opnd_reg  <= '0;
        end else if (phase_reg == NSX_Q1) begin
            instr_reg <= instr_word;
        end else if (phase_reg == NSX_Q2) begin
            if (instr_reg[OPC_HI:OPC_LO] == OPC_LITERAL_XOR) begin
                opnd_reg <= instr_reg[DATA_W-1:0];
            end else begin
                opnd_reg <= file_mem[instr_reg[FADDR_W-1:0]];
            end
        end
    end

    // ----------------------------------------------------------------
    // q3 process
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            res_reg      <= '0;
            res_zero_reg <= 1'b0;
            res_file_reg <= 1'b0;
            op_reg       <= NSX_OP_NONE;
        end else if (phase_reg == NSX_Q3) begin
            res_reg      <= alu_res;
            res_zero_reg <= alu_zero;
            res_file_reg <= alu_file;
            op_reg       <= alu_op;
        end
    end

    // ----------------------------------------------------------------
    // q4 write to destination
    // ----------------------------------------------------------------
    assign commit      = (phase_reg == NSX_Q4);
    assign file_commit = commit && (op_reg == NSX_OP_SWAP) && res_file_reg;
    assign dir_commit  = commit && (op_reg == NSX_OP_DIR) && nsx_dir_sel_ok(instr_reg[DIRSEL_W-1:0]);
    assign dir_idx     = nsx_dir_index(instr_reg[DIRSEL_W-1:0]);

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // the instruction write wins over a same-cycle port write, which is dropped whatever cell it addresses
    always_ff @(posedge clk) begin
        if (file_commit) begin
            file_mem[instr_reg[FADDR_W-1:0]] <= res_reg;
        end else if (file_wr_en) begin
            file_mem[file_wr_addr] <= file_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_reg <= file_mem[file_rd_addr];
    end

    // ----------------------------------------------------------------
    // working register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            w_reg <= W_RESET;
        end else if (commit && (op_reg == NSX_OP_XOR)) begin
            w_reg <= res_reg;
        end else if (commit && (op_reg == NSX_OP_SWAP) && !res_file_reg) begin
            w_reg <= res_reg;
        end
    end

    // ----------------------------------------------------------------
    // direction registers
    // ----------------------------------------------------------------
    // direct port writes stay available so software need not use the legacy load
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DIR_COUNT; i++) begin
                dir_reg[i] <= DIR_RESET;
            end
        end else if (dir_commit) begin
            dir_reg[dir_idx] <= w_reg;
        end else if (dir_wr_en && nsx_dir_sel_ok(dir_wr_sel)) begin
            dir_reg[nsx_dir_index(dir_wr_sel)] <= dir_wr_data;
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    // of the instructions only the literal xor touches zero; swap and load never reach these flags
    always_ff @(posedge clk) begin
        if (rst) begin
            z_reg  <= FLAG_RST;
            c_reg  <= FLAG_RST;
            dc_reg <= FLAG_RST;
        end else if (commit && (op_reg == NSX_OP_XOR)) begin
            z_reg <= res_zero_reg;
        end else if (status_wr_en) begin
            z_reg  <= status_wr_data[2];
            dc_reg <= status_wr_data[1];
            c_reg  <= status_wr_data[0];
        end
    end

    // ----------------------------------------------------------------
    // retire and fault pulses
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            retire_reg  <= 1'b0;
            unknown_reg <= 1'b0;
        end else begin
            retire_reg  <= commit;
            unknown_reg <= commit && ((op_reg == NSX_OP_NONE)
                           || ((op_reg == NSX_OP_DIR) && !nsx_dir_sel_ok(instr_reg[DIRSEL_W-1:0])));
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign file_rd_data     = rd_reg;
    assign w_out            = w_reg;
    assign zero_flag        = z_reg;
    assign carry_flag       = c_reg;
    assign digit_carry_flag = dc_reg;
    assign dir5_out         = dir_reg[0];
    assign dir6_out         = dir_reg[1];
    assign dir7_out         = dir_reg[2];
    assign phase_out        = phase_reg;
    assign retire_pulse     = retire_reg;
    assign unknown_op_pulse = unknown_reg;
endmodule
`default_nettype wire

// ==== tb/nsx_exec_chk.sv ====
// concurrent checks on the executer ports
`timescale 1ns/1ns
`default_nettype none
module nsx_exec_chk
    import nsx_pkg::*;
(
    input wire logic               clk,
    input wire logic               rst,
    input wire logic [INSTR_W-1:0] instr_word,
    input wire logic               status_wr_en,
    input wire logic [DATA_W-1:0]  w_out,
    input wire logic               zero_flag,
    input wire logic               carry_flag,
    input wire logic               digit_carry_flag,
    input wire logic [DATA_W-1:0]  dir6_out,
    input wire logic [1:0]         phase_out,
    input wire logic               retire_pulse,
    input wire logic               unknown_op_pulse
);
    // ------------------------------------------------------------
    // helper: remembers whether the running word is a literal xor
    // ------------------------------------------------------------
    logic xor_cur_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            xor_cur_reg <= 1'b0;
        end else if (phase_out == 2'h0) begin
            xor_cur_reg <= (instr_word[13:8] == OPC_LITERAL_XOR);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_xor;
        phase_out == 2'h0 && instr_word[13:8] == OPC_LITERAL_XOR;
    endsequence
    sequence s_swap_file;
        phase_out == 2'h0 && instr_word[13:8] == OPC_NIBBLE_SWAP && instr_word[DEST_BIT];
    endsequence
    sequence s_dir6;
        phase_out == 2'h0 && instr_word[13:3] == OPC_DIR_LOAD && instr_word[2:0] == 3'h6;
    endsequence
    sequence s_dir_bad;
        phase_out == 2'h0 && instr_word[13:3] == OPC_DIR_LOAD && instr_word[2:0] < 3'h5;
    endsequence
    AST_PHASE_STEP: assert property (1'b1 |=> phase_out == $past(phase_out) + 2'h1)
        else $error("quarter phase did not advance by one");
    AST_RETIRE: assert property (1'b1 |=> retire_pulse == $past(phase_out == 2'h3))
        else $error("retire pulse not one cycle after the fourth quarter");
    AST_XOR_W: assert property (s_xor |-> ##4 w_out == ($past(w_out, 4) ^ $past(instr_word[7:0], 4)))
        else $error("literal xor result wrong");
    AST_XOR_Z: assert property (s_xor |-> ##4 zero_flag == (w_out == 8'h00))
        else $error("zero flag does not follow xor result");
    AST_SWAP_KEEP_W: assert property (s_swap_file |=> $stable(w_out) [*4])
        else $error("swap to file register touched working register");
    AST_CARRY_KEEP: assert property (!status_wr_en |=> $stable({carry_flag, digit_carry_flag}))
        else $error("carry flags changed without a status write");
    AST_ZERO_KEEP: assert property (!status_wr_en && !(phase_out == 2'h3 && xor_cur_reg)
        |=> $stable(zero_flag))
        else $error("zero flag changed outside a literal xor");
    AST_DIR_LOAD: assert property (s_dir6 |-> ##4 dir6_out == $past(w_out, 4))
        else $error("direction load did not copy working register");
    AST_DIR_BAD: assert property (s_dir_bad |-> ##4 unknown_op_pulse && retire_pulse)
        else $error("direction load with low operand not flagged");
endmodule
bind nsx_exec nsx_exec_chk u_chk (.clk, .rst, .instr_word, .status_wr_en, .w_out, .zero_flag, .carry_flag,
    .digit_carry_flag, .dir6_out, .phase_out, .retire_pulse, .unknown_op_pulse);
`default_nettype wire

// ==== tb/nsx_prog_mem.sv ====
// program memory model feeding one word per instruction slot
`timescale 1ns/1ns
`default_nettype none
module nsx_prog_mem
    import nsx_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [1:0]         phase,
    output logic [INSTR_W-1:0]      instr_word,
    output logic                    done_real
);
    logic [INSTR_W-1:0] q[$];
    logic               real_reg;
    task automatic load(input logic [INSTR_W-1:0] w);
        q.push_back(w);
    endtask
    // new word appears for the slot after the fourth quarter and stands all four quarters
    always @(posedge clk) begin
        if (rst) begin
            instr_word <= 14'h3FFF;
            real_reg   <= 1'b0;
            done_real  <= 1'b0;
        end else if (phase == 2'h3) begin
            done_real  <= real_reg;
            real_reg   <= (q.size() != 0);
            // idle slots read as a pulled-up bus, which decodes to no operation
            instr_word <= (q.size() != 0) ? q.pop_front() : 14'h3FFF;
        end
    end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the executer
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import nsx_pkg::*;
    logic clk, rst, file_wr_en, dir_wr_en, status_wr_en, zero_flag, carry_flag, digit_carry_flag;
    logic retire_pulse, unknown_op_pulse, done_real;
    logic [INSTR_W-1:0]  instr_word;
    logic [FADDR_W-1:0]  file_wr_addr, file_rd_addr;
    logic [DATA_W-1:0]   file_wr_data, dir_wr_data, file_rd_data, w_out, dir5_out, dir6_out, dir7_out, exp_w;
    logic [DIRSEL_W-1:0] dir_wr_sel;
    logic [2:0]          status_wr_data;
    logic [1:0]          phase_out;
    int                  err_total, tests_run;
    nsx_exec DUT (.clk, .rst, .instr_word, .file_wr_en, .file_wr_addr, .file_wr_data, .file_rd_addr, .dir_wr_en,
        .dir_wr_sel, .dir_wr_data, .status_wr_en, .status_wr_data, .file_rd_data, .w_out, .zero_flag, .carry_flag,
        .digit_carry_flag, .dir5_out, .dir6_out, .dir7_out, .phase_out, .retire_pulse, .unknown_op_pulse);
    nsx_prog_mem u_mem (.clk, .rst, .phase(phase_out), .instr_word, .done_real);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // returns in the retire cycle of the word, when results are visible
    task automatic exec(input logic [INSTR_W-1:0] word);
        int n;
        u_mem.load(word);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!(retire_pulse === 1'b1 && done_real === 1'b1) && n < 20);
        if (n >= 20) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic poke(input logic [2:0] kind, input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] d);
        {file_wr_en, dir_wr_en, status_wr_en} = kind;
        file_wr_addr = a[6:0];
        dir_wr_sel = a[2:0];
        file_wr_data = d;
        dir_wr_data = d;
        status_wr_data = d[2:0];
        @(posedge clk);
        #1;
        {file_wr_en, dir_wr_en, status_wr_en} = 3'h0;
        // let an edge pass so a following poke never re-raises a strobe in this time step
        @(posedge clk);
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_xor();
        logic [DATA_W-1:0] k [3] = '{8'hB5, 8'hB5, 8'hFF};
        poke(3'h1, 8'h00, 8'h03);
        exp_w = 8'h00;
        for (int i = 0; i < 3; i++) begin
            exec({OPC_LITERAL_XOR, k[i]});
            exp_w = exp_w ^ k[i];
            check(w_out, exp_w);
            check({7'h00, zero_flag}, {7'h00, exp_w == 8'h00});
            check({6'h00, carry_flag, digit_carry_flag}, 8'h03);
        end
        $display("done: literal xor");
    endtask
    task automatic t_swap();
        poke(3'h4, 8'h7F, 8'hA5);
        poke(3'h1, 8'h00, 8'h07);
        exec({OPC_NIBBLE_SWAP, 1'b0, 7'h7F});
        check(w_out, 8'h5A);
        exec({OPC_NIBBLE_SWAP, 1'b1, 7'h7F});
        file_rd_addr = 7'h7F;
        @(posedge clk);
        #1;
        check(file_rd_data, 8'h5A);
        check(w_out, 8'h5A);
        check({5'h00, zero_flag, digit_carry_flag, carry_flag}, 8'h07);
        $display("done: nibble swap");
    endtask
    task automatic t_dir();
        for (int s = 5; s < 8; s++) begin
            exec({OPC_DIR_LOAD, 3'(s)});
            check(s == 5 ? dir5_out : s == 6 ? dir6_out : dir7_out, 8'h5A);
            check({7'h00, unknown_op_pulse}, 8'h00);
        end
        poke(3'h2, 8'h05, 8'h3C);
        exec({OPC_DIR_LOAD, 3'h4});
        check({7'h00, unknown_op_pulse}, 8'h01);
        check(dir5_out, 8'h3C);
        poke(3'h2, 8'h06, 8'hC3);
        check(dir6_out, 8'hC3);
        check({5'h00, zero_flag, digit_carry_flag, carry_flag}, 8'h07);
        $display("done: direction load");
    endtask
    initial begin
        err_total = 0;
        tests_run = 0;
        rst = 1'b1;
        {file_wr_en, dir_wr_en, status_wr_en} = 3'h0;
        {file_wr_addr, file_rd_addr, dir_wr_sel, status_wr_data} = '0;
        {file_wr_data, dir_wr_data} = '0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        check(w_out, W_RESET);
        check(dir7_out, DIR_RESET);
        t_xor();
        t_swap();
        t_dir();
        give_verdict();
    end
endmodule
`default_nettype wire
